// ===== rtl/cable_fault_diagnostic_control.v
// Cable fault diagnostic control, result register and link state register
`timescale 1ns/1ns
`include "cable_diag_consts.vh"
module cable_fault_diagnostic_control #(
    parameter        QUIET_CYC  = `QUIET_CYC_DEF,
    parameter        BUSY_CYC   = `BUSY_CYC_DEF,
    parameter        FIRE_CYC   = `FIRE_CYC_DEF,
    parameter        LISTEN_CYC = `LISTEN_CYC_DEF,
    parameter [9:0]  THR_HIGH   = `THR_HIGH_DEF,
    parameter [9:0]  THR_LOW    = `THR_LOW_DEF
) (
    input  wire        core_clk,
    input  wire        nrst,
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    output reg         reg_rdata_valid,
    input  wire [8:0]  sampled_echo_level,
    input  wire        fast_signal_mask,
    input  wire        fast_pulse_detect,
    input  wire        link_1000_good,
    input  wire        link_100_good,
    output reg         tx_enable,
    output reg         tdr_pulse,
    output reg  [1:0]  test_pair,
    output reg         test_active
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset and state encodings

    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_QUIET  = 3'h1;
    localparam [2:0] ST_FIRE   = 3'h2;
    localparam [2:0] ST_LISTEN = 3'h3;
    localparam [2:0] ST_DONE   = 3'h4;

    localparam [7:0] PW_MAX = `PW_MAX_CYC;
    localparam [7:0] PW_MIN = `PW_MIN_CYC;

    wire srst_n;

    reset_sync u_reset_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .srst_n   (srst_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    reg        run_r;
    reg        tx_inhibit_r;
    reg [1:0]  pair_r;
    reg [1:0]  view_r;
    reg [1:0]  verdict_r;
    reg [7:0]  payload_r;
    reg        link_1000_r;
    reg        link_100_r;

    wire wr_test  = reg_wr && (reg_addr == `REG_IDX_CABLE_TEST);
    wire start    = wr_test && reg_wdata[`FLD_RUN] && !run_r;
    wire abort    = wr_test && !reg_wdata[`FLD_RUN];
    wire finish;

    // Run bit: write one starts, write zero stops, hardware clears at end
    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            run_r <= 1'b0;
        end else if (start) begin
            run_r <= 1'b1; // R1
        end else if (abort) begin
            run_r <= 1'b0; // R2
        end else if (finish) begin
            run_r <= 1'b0; // R1
        end
    end

    // Plain read/write fields
    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            tx_inhibit_r <= 1'b0;
            pair_r       <= 2'h0;
            view_r       <= `VIEW_RESULT;
        end else if (wr_test) begin
            tx_inhibit_r <= reg_wdata[`FLD_TX_INHIBIT];
            pair_r       <= reg_wdata[`FLD_PAIR_HI:`FLD_PAIR_LO];
            view_r       <= reg_wdata[`FLD_VIEW_HI:`FLD_VIEW_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Echo classification against the pulse thresholds

    wire signed [9:0] echo_s   = {sampled_echo_level[8], sampled_echo_level};
    wire signed [9:0] thr_hi_s = THR_HIGH;
    wire signed [9:0] thr_lo_s = THR_LOW;
    wire              above    = echo_s > thr_hi_s; // R7
    wire              below    = echo_s < thr_lo_s; // R8
    wire              line_hot = above || below;

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequencer

    reg [2:0]  state_r;
    reg [15:0] quiet_cnt_r;
    reg [15:0] busy_cnt_r;
    reg [7:0]  time_r;
    reg [7:0]  first_time_r;
    reg [7:0]  width_r;
    reg        in_pulse_r;
    reg        pulse_pol_r;
    reg        first_seen_r;
    reg        first_pol_r;
    reg        first_done_r;
    reg        width_bad_r;
    reg [3:0]  fail_r;

    wire [1:0] low_cnt;
    wire [1:0] high_cnt;
    wire       clr_cnt   = start;
    wire       edge_in   = (state_r == ST_LISTEN) && line_hot && !in_pulse_r;
    wire [1:0] inc_cnt   = {edge_in && below, edge_in && above};
    wire [1:0] cnt_q [0:1];

    // One saturating counter per echo polarity: index 0 high, index 1 low
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pulse_cnt
            sat_pulse_counter #(
                .WIDTH (2)
            ) u_cnt (
                .core_clk (core_clk),
                .srst_n   (srst_n),
                .clr      (clr_cnt),
                .inc      (inc_cnt[gi]),
                .cnt_r    (cnt_q[gi])
            );
        end
    endgenerate

    assign high_cnt = cnt_q[0];
    assign low_cnt  = cnt_q[1];
    assign finish   = (state_r == ST_DONE);

    wire       width_ends = (state_r == ST_LISTEN) && in_pulse_r && !line_hot && !first_done_r;
    wire       width_out  = (width_r >= PW_MAX) || (width_r <= PW_MIN);
    wire [8:0] dist_sum   = {1'b0, first_time_r} + `DIST_OFFSET;

    // Sequencer: wait for a silent window, fire, then time and measure echoes
    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            state_r      <= ST_IDLE;
            quiet_cnt_r  <= 16'h0000;
            busy_cnt_r   <= 16'h0000;
            time_r       <= 8'h00;
            first_time_r <= 8'h00;
            width_r      <= 8'h00;
            in_pulse_r   <= 1'b0;
            pulse_pol_r  <= 1'b0;
            first_seen_r <= 1'b0;
            first_pol_r  <= 1'b0;
            first_done_r <= 1'b0;
            width_bad_r  <= 1'b0;
            fail_r       <= 4'h0;
        end else if (abort) begin
            state_r <= ST_IDLE; // R2
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r      <= ST_QUIET;
                        quiet_cnt_r  <= 16'h0000;
                        busy_cnt_r   <= 16'h0000;
                        first_seen_r <= 1'b0;
                        first_done_r <= 1'b0;
                        width_bad_r  <= 1'b0;
                        in_pulse_r   <= 1'b0;
                        fail_r       <= 4'h0;
                    end
                end
                ST_QUIET: begin
                    if (tx_inhibit_r) begin
                        quiet_cnt_r <= 16'h0000; // R4
                    end else if (fast_signal_mask) begin
                        fail_r[`FAIL_BIT_FAST_MASK - 4] <= 1'b1; // R13
                        state_r <= ST_DONE;
                    end else if (fast_pulse_detect) begin
                        fail_r[`FAIL_BIT_FAST_PULSE - 4] <= 1'b1; // R13
                        state_r <= ST_DONE;
                    end else if (line_hot) begin
                        quiet_cnt_r <= 16'h0000;
                        busy_cnt_r  <= busy_cnt_r + 16'h0001;
                        if (busy_cnt_r == BUSY_CYC[15:0] - 16'h0001) begin
                            fail_r[`FAIL_BIT_LONG_SIGNAL - 4] <= 1'b1; // R13
                            state_r <= ST_DONE;
                        end
                    end else if (quiet_cnt_r == QUIET_CYC[15:0] - 16'h0001) begin
                        state_r <= ST_FIRE;
                        time_r  <= 8'h00;
                    end else begin
                        busy_cnt_r  <= 16'h0000;
                        quiet_cnt_r <= quiet_cnt_r + 16'h0001;
                    end
                end
                ST_FIRE: begin
                    time_r <= time_r + 8'h01;
                    if (time_r == FIRE_CYC[7:0] - 8'h01) begin
                        state_r <= ST_LISTEN;
                        time_r  <= 8'h00;
                    end
                end
                ST_LISTEN: begin
                    time_r <= time_r + 8'h01;
                    if (edge_in) begin
                        in_pulse_r  <= 1'b1;
                        pulse_pol_r <= above;
                        width_r     <= 8'h01;
                        if (!first_seen_r) begin
                            first_seen_r <= 1'b1;
                            first_pol_r  <= above;
                            first_time_r <= time_r;
                        end
                    end else if (in_pulse_r) begin
                        if (line_hot && (above == pulse_pol_r)) begin
                            if (width_r != 8'hff) begin
                                width_r <= width_r + 8'h01;
                            end
                        end else begin
                            in_pulse_r <= 1'b0;
                        end
                    end
                    if (width_ends) begin
                        first_done_r <= 1'b1;
                        width_bad_r  <= width_out; // R12
                    end
                    if (time_r == LISTEN_CYC[7:0] - 8'h01) begin
                        state_r <= ST_DONE;
                        if (in_pulse_r && !first_done_r) begin
                            width_bad_r <= 1'b1; // R12
                        end
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and payload, held until the next start

    // Latched once at the end of a test so reads never see a half result
    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            verdict_r <= `VERDICT_NORMAL;
            payload_r <= 8'h00;
        end else if (start) begin
            verdict_r <= `VERDICT_NORMAL; // R17
            payload_r <= 8'h00;
        end else if (finish && !abort) begin
            if ((fail_r != 4'h0) || width_bad_r) begin
                verdict_r <= `VERDICT_FAILED; // R9
                payload_r <= {width_bad_r, fail_r[2:0], low_cnt, high_cnt}; // R12 R13 R14
            end else if (!first_seen_r) begin
                verdict_r <= `VERDICT_NORMAL; // R9
                payload_r <= 8'h00;
            end else begin
                verdict_r <= first_pol_r ? `VERDICT_OPEN : `VERDICT_SHORT; // R9
                payload_r <= dist_sum[8] ? 8'hff : dist_sum[7:0]; // R11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link state capture and pin outputs

    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            link_1000_r <= 1'b0;
            link_100_r  <= 1'b0;
            tx_enable   <= 1'b0;
            tdr_pulse   <= 1'b0;
            test_pair   <= 2'h0;
            test_active <= 1'b0;
        end else begin
            link_1000_r <= link_1000_good; // R15
            link_100_r  <= link_100_good; // R16
            tx_enable   <= !tx_inhibit_r; // R4
            tdr_pulse   <= (state_r == ST_FIRE);
            test_pair   <= pair_r; // R5
            test_active <= run_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port

    reg [9:0]  low_view;
    reg [15:0] rd_mux;

    // Low ten bits change meaning with the view select field
    always @* begin
        case (view_r)
            `VIEW_RESULT:   low_view = {verdict_r, payload_r}; // R6 R10
            `VIEW_THR_HIGH: low_view = THR_HIGH; // R6 R7
            `VIEW_THR_LOW:  low_view = THR_LOW; // R6 R8
            default:        low_view = 10'h000;
        endcase
    end

    // Unmapped indices read as zero
    always @* begin
        case (reg_addr)
            `REG_IDX_CABLE_TEST: rd_mux = {run_r, tx_inhibit_r, pair_r, view_r, low_view}; // R3
            `REG_IDX_LINK_STATE: rd_mux = {14'h0000, link_1000_r, link_100_r}; // R15 R16
            default:             rd_mux = 16'h0000;
        endcase
    end

    // Read data is registered one cycle after the strobe
    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            reg_rdata       <= 16'h0000;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

endmodule // cable_fault_diagnostic_control

// ===== rtl/cable_diag_consts.vh
// Constants for the cable fault diagnostic control block
// Behaviour
// R1: Writing run bit one starts test, self-clears.
// R2: Writing run bit zero stops running test.
// R3: Run bit reads one while testing, zero done.
// R4: Inhibit bit disables transmitter, holds test; code holds the test in its quiet phase only.
// R5: Pair select 00..11 picks pairs A..D.
// R6: View select picks result, high or low threshold.
// R7: High pulse threshold defaults to 64.
// R8: Low pulse threshold defaults to minus 64.
// R9: Verdict: none, open, short, test failed.
// R10: Verdict valid only in result view, idle.
// R11: Software: distance equals 0.8 times (payload-22).
// R12: Failed test bit 7 flags bad pulse width.
// R13: Failed test bits 6..4 flag line activity causes.
// R14: Failed test low/high pulse counts saturate at 3.
// R15: Status bit 1 shows gigabit link good.
// R16: Status bit 0 shows fast link good.
// R17: Last verdict held until new test starts.
`ifndef CABLE_DIAG_CONSTS_VH
`define CABLE_DIAG_CONSTS_VH

// Register indices on the management register port
`define REG_IDX_CABLE_TEST     5'h12
`define REG_IDX_LINK_STATE     5'h13

// Cable test control/result field positions
`define FLD_RUN                15
`define FLD_TX_INHIBIT         14
`define FLD_PAIR_HI            13
`define FLD_PAIR_LO            12
`define FLD_VIEW_HI            11
`define FLD_VIEW_LO            10

// Link state field positions
`define FLD_LINK_1000          1
`define FLD_LINK_100           0

// View select encodings
`define VIEW_RESULT            2'h0
`define VIEW_THR_HIGH          2'h1
`define VIEW_THR_LOW           2'h2

// Verdict encodings
`define VERDICT_NORMAL         2'h0
`define VERDICT_OPEN           2'h1
`define VERDICT_SHORT          2'h2
`define VERDICT_FAILED         2'h3

// Failure cause bit positions within the payload
`define FAIL_BIT_WIDTH         7
`define FAIL_BIT_LONG_SIGNAL   6
`define FAIL_BIT_FAST_MASK     5
`define FAIL_BIT_FAST_PULSE    4

// Reset values and distance offset
`define THR_HIGH_DEF           10'h040
`define THR_LOW_DEF            10'h3c0
`define DIST_OFFSET            9'h016

// Timing
`define CLK_PERIOD_NS          10
`define PW_MAX_NS              152
`define PW_MIN_NS              48
`define PW_MAX_CYC             ((`PW_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PW_MIN_CYC             (`PW_MIN_NS / `CLK_PERIOD_NS)
`define QUIET_CYC_DEF          64
`define BUSY_CYC_DEF           256
`define FIRE_CYC_DEF           2
`define LISTEN_CYC_DEF         255

`endif

// ===== rtl/reset_sync.v
// Reset synchroniser: asynchronous assert, release through two flip-flops
`timescale 1ns/1ns
module reset_sync (
    input  wire core_clk,
    input  wire nrst,
    output wire srst_n
);

    reg [1:0] sync_r;

    // Release is aligned to the clock so no flop sees a partial release
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync_r <= 2'h0;
        end else begin
            sync_r <= {sync_r[0], 1'b1};
        end
    end

    assign srst_n = sync_r[1];

endmodule // reset_sync

// ===== rtl/sat_pulse_counter.v
// Saturating event counter with synchronous clear
`timescale 1ns/1ns
module sat_pulse_counter #(
    parameter WIDTH = 2
) (
    input  wire             core_clk,
    input  wire             srst_n,
    input  wire             clr,
    input  wire             inc,
    output reg  [WIDTH-1:0] cnt_r
);

    // Sticks at all ones so a burst of echoes cannot wrap to a small count
    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            cnt_r <= {WIDTH{1'b0}};
        end else if (clr) begin
            cnt_r <= {WIDTH{1'b0}};
        end else if (inc && (cnt_r != {WIDTH{1'b1}})) begin
            cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1}; // R14
        end
    end

endmodule // sat_pulse_counter

// ===== dv/cable_partner_model.sv
// Behavioural model of the cable and remote link partner
`timescale 1ns/1ns
module cable_partner_model #(
    parameter ECHO_DLY = 10
) (
    input  wire       core_clk,
    input  wire       tx_enable,
    input  wire       tdr_pulse,
    input  wire       test_active,
    input  wire [2:0] mode,
    input  wire [1:0] link_speed,
    output reg  [8:0] sampled_echo_level,
    output reg        fast_signal_mask,
    output reg        fast_pulse_detect,
    output wire       link_1000_good,
    output wire       link_100_good
);
    integer t = -1;

    ////////////////////////////////////////////////////////////////////////
    // Cycles since the probe pulse ended; the line is silent outside a test
    always @(posedge core_clk) begin
        if (!test_active)
            t <= -1;
        else if (tdr_pulse)
            t <= 0;
        else if (t >= 0)
            t <= t + 1;
    end

    // Echo shape per mode: open, short, over-long echo plus a pulse train
    always @* begin
        sampled_echo_level = 9'h000;
        if (mode == 3'd6 && test_active)
            sampled_echo_level = 9'h064; // Busy line never goes quiet
        else if (mode == 3'd1 && t >= ECHO_DLY && t < ECHO_DLY + 8)
            sampled_echo_level = 9'h050;
        else if (mode == 3'd2 && t >= ECHO_DLY && t < ECHO_DLY + 8)
            sampled_echo_level = 9'h1b0;
        else if (mode == 3'd3 && t >= 2 && t < 22)
            sampled_echo_level = 9'h050; // Over-long first echo
        else if (mode == 3'd3 && t >= 24 && t < 38 && !t[1])
            sampled_echo_level = 9'h1b0; // Four short low pulses, count must stick at 3
        fast_signal_mask  = (mode == 3'd4) && test_active; // Forced-mode partner traffic
        fast_pulse_detect = (mode == 3'd5) && test_active;
    end

    // Partner keeps a link only while our transmitter runs
    assign link_1000_good = tx_enable & link_speed[1];
    assign link_100_good  = tx_enable & link_speed[0];
endmodule // cable_partner_model

// ===== dv/cable_fault_diagnostic_control_chk.sv
// Port-level assertion checker for the cable diagnostic control block
`timescale 1ns/1ns
module cable_diag_chk #(
    parameter FIRE_CYC = 2
) (
    input wire        core_clk,
    input wire        nrst,
    input wire [4:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        reg_rdata_valid,
    input wire        link_1000_good,
    input wire        link_100_good,
    input wire        tx_enable,
    input wire        tdr_pulse,
    input wire [1:0]  test_pair,
    input wire        test_active
);
    reg [7:0] fire_cnt_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    // Length of the current probe pulse, counted so any FIRE_CYC is checkable
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            fire_cnt_r <= 8'h00;
        else
            fire_cnt_r <= tdr_pulse ? fire_cnt_r + 8'h01 : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    AST_RD_ANSWER: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read not answered one cycle later");
    AST_RD_ONE: assert property (!reg_rd |=> !reg_rdata_valid)
        else $error("read answer without a read");
    AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_TX_INHIBIT: assert property (reg_wr && reg_addr == 5'h12 |=> ##1 tx_enable == !$past(reg_wdata[14], 2))
        else $error("transmitter enable does not follow inhibit");
    AST_PAIR: assert property (reg_wr && reg_addr == 5'h12 |=> ##1 test_pair == $past(reg_wdata[13:12], 2))
        else $error("tested pair does not follow select");
    AST_ABORT: assert property (reg_wr && reg_addr == 5'h12 && !reg_wdata[15] |=> ##1 !test_active)
        else $error("test still active after stop");
    AST_START: assert property (reg_wr && reg_addr == 5'h12 && reg_wdata[15] && !test_active |=> ##1 test_active)
        else $error("test did not start");
    AST_FIRE_LEN: assert property ($fell(tdr_pulse) |-> fire_cnt_r == FIRE_CYC)
        else $error("probe pulse length wrong");
    AST_FIRE_OK: assert property (tdr_pulse |-> test_active && tx_enable && fire_cnt_r < FIRE_CYC)
        else $error("probe pulse outside an enabled test");
    AST_LINK: assert property (reg_rd && reg_addr == 5'h13 && $stable(link_1000_good) && $stable(link_100_good)
        |=> reg_rdata == {14'h0000, $past(link_1000_good), $past(link_100_good)})
        else $error("link state read wrong");
endmodule // cable_diag_chk

bind cable_fault_diagnostic_control cable_diag_chk #(.FIRE_CYC(FIRE_CYC)) u_chk (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .link_1000_good(link_1000_good),
    .link_100_good(link_100_good), .tx_enable(tx_enable), .tdr_pulse(tdr_pulse), .test_pair(test_pair),
    .test_active(test_active));

// ===== dv/cable_fault_diagnostic_control_tb.sv
// Self-checking testbench for the cable diagnostic control block
`timescale 1ns/1ns
module cable_fault_diagnostic_control_tb;
    reg         core_clk;
    reg         nrst;
    reg  [4:0]  reg_addr;
    reg  [15:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [15:0] reg_rdata;
    wire        reg_rdata_valid;
    wire [8:0]  sampled_echo_level;
    wire        fast_signal_mask;
    wire        fast_pulse_detect;
    wire        link_1000_good;
    wire        link_100_good;
    wire        tx_enable;
    wire        tdr_pulse;
    wire [1:0]  test_pair;
    wire        test_active;
    reg  [2:0]  mode;
    reg  [1:0]  link_speed;
    reg  [15:0] rv;
    reg  [15:0] keep;
    integer     error_cnt = 0;
    integer     compares = 0;
    integer     cyc = 0;
    integer     i;

    cable_fault_diagnostic_control #(.QUIET_CYC(4), .BUSY_CYC(8), .LISTEN_CYC(40)) u_dut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .sampled_echo_level(sampled_echo_level), .fast_signal_mask(fast_signal_mask),
        .fast_pulse_detect(fast_pulse_detect), .link_1000_good(link_1000_good), .link_100_good(link_100_good),
        .tx_enable(tx_enable), .tdr_pulse(tdr_pulse), .test_pair(test_pair), .test_active(test_active));

    cable_partner_model #(.ECHO_DLY(10)) u_line (
        .core_clk(core_clk), .tx_enable(tx_enable), .tdr_pulse(tdr_pulse), .test_active(test_active),
        .mode(mode), .link_speed(link_speed), .sampled_echo_level(sampled_echo_level),
        .fast_signal_mask(fast_signal_mask), .fast_pulse_detect(fast_pulse_detect),
        .link_1000_good(link_1000_good), .link_100_good(link_100_good));

    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string what, input [15:0] seen, input [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register port: one-cycle strobes, read answer sampled mid-cycle while it stands
    task wr(input [4:0] a, input [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task rd(input [4:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        chk("rdata_valid", {15'h0000, reg_rdata_valid}, 16'h0001);
        rv = reg_rdata;
    endtask

    // Start a test on a given line condition and compare the masked low ten bits
    task run_test(input [2:0] m, input [9:0] msk, input [9:0] exp);
        @(posedge core_clk);
        mode <= m;
        wr(5'h12, 16'h8000);
        rd(5'h12);
        chk("run_busy", {15'h0000, rv[15]}, 16'h0001);
        i = 0;
        while (rv[15] !== 1'b0 && i < 200) begin
            rd(5'h12);
            i = i + 1;
        end
        chk("run_clear", {15'h0000, rv[15]}, 16'h0000);
        chk("result", {6'h00, rv[9:0] & msk}, {6'h00, exp});
        $display("test line mode %0d done", m);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard: the whole sequence needs a few hundred cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            $display("timeout after %0d cycles", cyc);
            print_verdict;
        end
    end

    initial begin
        nrst = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mode = 3'd0;
        link_speed = 2'b00;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(5'h12);
        chk("ctrl_reset", rv, 16'h0000);
        rd(5'h13);
        chk("link_reset", rv, 16'h0000);
        rd(5'h05);
        chk("unmapped", rv, 16'h0000);
        $display("test reset values done");
        // Every pair and both threshold views; low ten bits must ignore writes
        for (i = 0; i < 4; i = i + 1) begin
            wr(5'h12, {2'b00, i[1:0], 2'b01, 10'h3ff});
            rd(5'h12);
            chk("thr_high", rv, {2'b00, i[1:0], 2'b01, 10'h040});
            chk("pair_port", {14'h0000, test_pair}, {14'h0000, i[1:0]});
            wr(5'h12, {2'b00, i[1:0], 2'b10, 10'h000});
            rd(5'h12);
            chk("thr_low", rv, {2'b00, i[1:0], 2'b10, 10'h3c0});
        end
        wr(5'h12, 16'h0000);
        $display("test views done");
        run_test(3'd0, 10'h3ff, 10'h000);
        run_test(3'd1, 10'h300, 10'h100);
        chk("distance", {15'h0000, rv[7:0] >= 8'd31 && rv[7:0] <= 8'd33}, 16'h0001);
        run_test(3'd2, 10'h300, 10'h200);
        run_test(3'd3, 10'h3ff, 10'h38d);
        run_test(3'd4, 10'h370, 10'h320);
        run_test(3'd5, 10'h370, 10'h310);
        run_test(3'd6, 10'h370, 10'h340);
        keep = rv;
        wr(5'h12, 16'h0400);
        wr(5'h12, 16'h0000);
        rd(5'h12);
        chk("held", rv, keep);
        $display("test held result done");
        @(posedge core_clk);
        mode <= 3'd0;
        link_speed <= 2'b10;
        rd(5'h13);
        chk("link_1000", rv, 16'h0002);
        link_speed <= 2'b01;
        rd(5'h13);
        chk("link_100", rv, 16'h0001);
        // Inhibit holds the test in its quiet phase and drops the link
        wr(5'h12, 16'hc000);
        repeat (30) @(posedge core_clk);
        chk("tx_off", {15'h0000, tx_enable}, 16'h0000);
        rd(5'h13);
        chk("link_down", rv, 16'h0000);
        rd(5'h12);
        chk("held_run", {15'h0000, rv[15]}, 16'h0001);
        wr(5'h12, 16'h0000);
        rd(5'h12);
        chk("abort", {15'h0000, rv[15]}, 16'h0000);
        chk("tx_on", {15'h0000, tx_enable}, 16'h0001);
        $display("test inhibit and abort done");
        print_verdict;
    end
endmodule // cable_fault_diagnostic_control_tb
